// *** rtl/ces_regs.svh ***
`ifndef CES_REGS_SVH
`define CES_REGS_SVH
// Overview of operation
// - Protected byte update: release line after clock 2
// - Protect bit set only when data bytes match
// - Protection write is 3C, address 00 to 1F
// - Programming takes 255 or 124 processing clocks
// - Security read: 32 bits out, then release
// - Unverified reads show zeros for reference bytes
// - Security read is 31, address and data ignored
// - Unverified update only clears error counter bits
// - Security update is 39, timed like main update
// - Compare is 33, addresses 01 to 03
// - Compare outside a verification sequence fails
// - Reader clears counter bit, then compares 1-3
// - Out of order sequence fails, no write access
// - Unverified counter bits never go back to one
// - Writing FF to counter after success erases it
// - Verified state grants writes to unprotected bytes until power-off
// - Retry allowed while a counter bit remains set
// - Failures release the line after 2 clocks

`define CES_CMD_RD_SEC 8'h31
`define CES_CMD_UPD_MAIN 8'h38
`define CES_CMD_WR_PROT 8'h3c
`define CES_CMD_UPD_SEC 8'h39
`define CES_CMD_CMP 8'h33
`define CES_PROT_LAST 8'h1f
`define CES_SEC_LAST 8'h03
`define CES_EC_ADR 8'h00
`define CES_STEP_LAST 2'h3
`define CES_MEM_BYTES 32'h00000100
`define CES_PROT_BITS 32'h00000020
`define CES_SEC_BYTES 32'h00000004
`define CES_FRAME_BITS 5'h18
`define CES_SEC_BITS 9'h020
`define CES_RD_CLKS 9'h021
`define CES_EW_CLKS 9'h0ff
`define CES_W_CLKS 9'h07c
`define CES_FAIL_CLKS 9'h002
`define CES_CMP_CLKS 9'h002
`define CES_EC_RST 8'h07
`define CES_MEM_RST 8'hff
`define CES_CODE_RST 24'hffffff
`define CES_CLK_KHZ 32'h0000c350
`define CES_LINK_KHZ 32'h00000032
`endif

// *** rtl/ces_pkg.sv ***
package ces_pkg;
    typedef enum logic [1:0] {D_IDLE, D_CMD, D_OUT, D_PROC} ces_dev_state_e;
    typedef enum logic [1:0] {OP_MAIN, OP_PROT, OP_SEC, OP_CMP} ces_op_e;
    typedef enum logic [2:0] {R_IDLE, R_START, R_BITS, R_STOP, R_CLKS, R_DONE} ces_rdr_state_e;
endpackage

// *** rtl/ces_link_if.sv ***
`timescale 1ns/1ns
interface ces_link_if;
    logic lnk_clk;
    logic lnk_rst;
    logic io_rdr_o;
    logic io_rdr_oe;
    logic io_dev_o;
    logic io_dev_oe;
    logic io;

    // Open drain with pull-up
    assign io = !((io_rdr_oe && !io_rdr_o) || (io_dev_oe && !io_dev_o));

    modport rdr (
        output lnk_clk, lnk_rst, io_rdr_o, io_rdr_oe,
        input io
    );
    modport dev (
        input lnk_clk, lnk_rst, io,
        output io_dev_o, io_dev_oe
    );
endinterface

// *** rtl/ces_fifo.sv ***
`timescale 1ns/1ns
module ces_fifo #(
    parameter int W = 24,
    parameter int D = 4
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** rtl/ces_card.sv ***
`timescale 1ns/1ns
`include "ces_regs.svh"
module ces_card #(
    parameter logic [23:0] CODE_INIT = `CES_CODE_RST
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // Link to reader
    ces_link_if.dev lnk,
    // Status
    output logic verified,
    output logic [2:0] err_count,
    output logic busy
);
    localparam int MB = `CES_MEM_BYTES;
    localparam int PB = `CES_PROT_BITS;
    localparam int SB = `CES_SEC_BYTES;

    ces_pkg::ces_dev_state_e st_q;
    ces_pkg::ces_op_e op_q;
    logic clk_q;
    logic io_q;
    logic [23:0] sr_q;
    logic [4:0] bit_q;
    logic [8:0] cnt_q;
    logic [8:0] tgt_q;
    logic fail_q;
    logic pull_q;
    logic [31:0] out_q;
    logic [7:0] mem_q [MB];
    logic [PB-1:0] prot_q;
    logic [7:0] secm_q [SB];
    logic verified_q;
    logic [1:0] step_q;
    logic seq_ok_q;

    // Link edges and framing conditions
    logic rise;
    logic fall;
    logic start;
    logic stop;
    assign rise = lnk.lnk_clk && !clk_q;
    assign fall = !lnk.lnk_clk && clk_q;
    // Own pull right after stop, clock still high, is not a start
    assign start = lnk.lnk_clk && clk_q && io_q && !lnk.io && !pull_q;
    assign stop = lnk.lnk_clk && clk_q && !io_q && lnk.io;

    // Command fields, control byte first
    logic [7:0] cmd;
    logic [7:0] adr;
    logic [7:0] dat;
    assign cmd = sr_q[7:0];
    assign adr = sr_q[15:8];
    assign dat = sr_q[23:16];

    logic is_rd;
    logic is_main;
    logic is_wrp;
    logic is_sec;
    logic is_cmp;
    logic known;
    assign is_rd = cmd == `CES_CMD_RD_SEC;
    assign is_main = cmd == `CES_CMD_UPD_MAIN;
    assign is_wrp = cmd == `CES_CMD_WR_PROT;
    assign is_sec = cmd == `CES_CMD_UPD_SEC;
    assign is_cmp = cmd == `CES_CMD_CMP;
    assign known = is_main || is_wrp || is_sec || is_cmp;

    logic [2:0] ec_q;
    logic [2:0] ec_new;
    logic ec_start;
    logic prot_adr_ok;
    logic prot_hit;
    logic main_ok;
    logic wrp_ok;
    logic sec_ok;
    logic cmp_in_seq;
    logic go_ok;
    assign ec_q = secm_q[0][2:0];
    // Unverified writes can only clear counter bits
    assign ec_new = verified_q ? dat[2:0] : (ec_q & dat[2:0]);
    // Sequence opens only if a still-set bit is cleared
    assign ec_start = !verified_q && adr == `CES_EC_ADR && ec_new != ec_q;
    assign prot_adr_ok = adr <= `CES_PROT_LAST;
    assign prot_hit = prot_adr_ok && prot_q[adr[4:0]];
    assign main_ok = verified_q && !prot_hit;
    // Rewriting a set protect bit counts as a failure too
    assign wrp_ok = verified_q && prot_adr_ok && !prot_hit && mem_q[adr] == dat;
    assign sec_ok = verified_q ? (adr <= `CES_SEC_LAST) : ec_start;
    assign cmp_in_seq = step_q != 2'h0 && adr == {6'h00, step_q};
    assign go_ok = is_main ? main_ok : is_wrp ? wrp_ok : is_sec ? sec_ok : cmp_in_seq;

    // Processing length from the old and new byte
    logic [7:0] old_b;
    logic [7:0] new_b;
    logic need_erase;
    logic need_write;
    logic [8:0] prog_clks;
    logic [8:0] tgt_d;
    ces_pkg::ces_op_e op_d;
    assign old_b = is_sec ? secm_q[adr[1:0]] : mem_q[adr];
    assign new_b = (is_sec && adr == `CES_EC_ADR) ? {5'h00, ec_new} : dat;
    assign need_erase = |(new_b & ~old_b);
    assign need_write = |(~new_b & old_b);
    assign prog_clks = (need_erase && need_write) ? `CES_EW_CLKS : `CES_W_CLKS;
    assign tgt_d = !go_ok ? `CES_FAIL_CLKS : is_cmp ? `CES_CMP_CLKS :
        is_wrp ? `CES_W_CLKS : prog_clks;
    assign op_d = is_main ? ces_pkg::OP_MAIN : is_wrp ? ces_pkg::OP_PROT :
        is_sec ? ces_pkg::OP_SEC : ces_pkg::OP_CMP;

    // Reference bytes masked until verified
    logic [7:0] ref_mask;
    logic [31:0] rd_word;
    assign ref_mask = {8{verified_q}};
    assign rd_word = {secm_q[3] & ref_mask, secm_q[2] & ref_mask,
        secm_q[1] & ref_mask, secm_q[0]};

    logic stop_cmd;
    logic frame_ok;
    logic done_p;
    logic commit;
    logic ref_match;
    assign stop_cmd = st_q == ces_pkg::D_CMD && stop && !lnk.lnk_rst;
    assign frame_ok = bit_q == `CES_FRAME_BITS;
    assign done_p = st_q == ces_pkg::D_PROC && fall && !lnk.lnk_rst && !start
        && (cnt_q + 9'h001) == tgt_q;
    assign commit = done_p && !fail_q;
    assign ref_match = secm_q[adr[1:0]] == dat;

    always_ff @(posedge clk) begin
        if (srst) begin
            clk_q <= 1'b0;
            io_q <= 1'b1;
        end else begin
            clk_q <= lnk.lnk_clk;
            io_q <= lnk.io;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= ces_pkg::D_IDLE;
            op_q <= ces_pkg::OP_MAIN;
            sr_q <= '0;
            bit_q <= '0;
            cnt_q <= '0;
            tgt_q <= '0;
            fail_q <= 1'b0;
            pull_q <= 1'b0;
            out_q <= '0;
        end else if (lnk.lnk_rst) begin
            st_q <= ces_pkg::D_IDLE;
            pull_q <= 1'b0;
        end else if (start) begin
            st_q <= ces_pkg::D_CMD;
            bit_q <= '0;
            pull_q <= 1'b0;
        end else begin
            case (st_q)
                ces_pkg::D_CMD: begin
                    if (rise && !frame_ok) begin
                        sr_q <= {lnk.io, sr_q[23:1]};
                        bit_q <= bit_q + 5'h01;
                    end else if (stop) begin
                        cnt_q <= '0;
                        if (frame_ok && is_rd) begin
                            out_q <= rd_word;
                            st_q <= ces_pkg::D_OUT;
                        end else if (frame_ok && known) begin
                            op_q <= op_d;
                            fail_q <= !go_ok;
                            tgt_q <= tgt_d;
                            pull_q <= 1'b1;
                            st_q <= ces_pkg::D_PROC;
                        end else begin
                            // Bad command or bit count: line stays released
                            st_q <= ces_pkg::D_IDLE;
                        end
                    end
                end
                ces_pkg::D_OUT: begin
                    if (fall) begin
                        if (cnt_q == `CES_SEC_BITS) begin
                            pull_q <= 1'b0;
                            st_q <= ces_pkg::D_IDLE;
                        end else begin
                            pull_q <= !out_q[0];
                            out_q <= {1'b0, out_q[31:1]};
                            cnt_q <= cnt_q + 9'h001;
                        end
                    end
                end
                ces_pkg::D_PROC: begin
                    if (done_p) begin
                        pull_q <= 1'b0;
                        st_q <= ces_pkg::D_IDLE;
                    end else if (fall) begin
                        cnt_q <= cnt_q + 9'h001;
                    end
                end
                default: begin
                    st_q <= ces_pkg::D_IDLE;
                end
            endcase
        end
    end

    // Memory; contents survive link resets, only power-up restores them
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < MB; i++) begin
                mem_q[i] <= `CES_MEM_RST;
            end
            prot_q <= '0;
            secm_q[0] <= `CES_EC_RST;
            secm_q[1] <= CODE_INIT[7:0];
            secm_q[2] <= CODE_INIT[15:8];
            secm_q[3] <= CODE_INIT[23:16];
        end else if (commit) begin
            case (op_q)
                ces_pkg::OP_MAIN: mem_q[adr] <= dat;
                ces_pkg::OP_PROT: prot_q[adr[4:0]] <= 1'b1;
                ces_pkg::OP_SEC: secm_q[adr[1:0]] <= new_b;
                default: begin
                end
            endcase
        end
    end

    // Verification sequence tracking
    always_ff @(posedge clk) begin
        if (srst) begin
            verified_q <= 1'b0;
            step_q <= 2'h0;
            seq_ok_q <= 1'b0;
        end else if (stop_cmd && !(frame_ok && is_cmp && cmp_in_seq)) begin
            step_q <= 2'h0;
        end else if (commit && op_q == ces_pkg::OP_SEC && ec_start) begin
            step_q <= 2'h1;
            seq_ok_q <= 1'b1;
        end else if (commit && op_q == ces_pkg::OP_CMP) begin
            seq_ok_q <= seq_ok_q && ref_match;
            step_q <= (step_q == `CES_STEP_LAST) ? 2'h0 : step_q + 2'h1;
            if (step_q == `CES_STEP_LAST && seq_ok_q && ref_match) begin
                verified_q <= 1'b1;
            end
        end
    end

    assign lnk.io_dev_o = 1'b0;
    assign lnk.io_dev_oe = pull_q;
    assign verified = verified_q;
    assign err_count = ec_q;
    assign busy = st_q != ces_pkg::D_IDLE;
endmodule

// *** rtl/ces_reader.sv ***
`timescale 1ns/1ns
`include "ces_regs.svh"
module ces_reader #(
    parameter logic [15:0] HALF = 16'((`CES_CLK_KHZ) / (2 * `CES_LINK_KHZ)),
    parameter int DEPTH = 4
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // Link to card
    ces_link_if.rdr lnk,
    // Command queue
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [23:0] cmd_word,
    input wire logic brk,
    // Response
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    output logic busy
);
    ces_pkg::ces_rdr_state_e st_q;
    logic [15:0] tmr_q;
    logic clk_o_q;
    logic drv_q;
    logic brk_q;
    logic [1:0] ph_q;
    logic [23:0] word_q;
    logic [4:0] bit_q;
    logic [8:0] n_q;
    logic [8:0] k_q;
    logic [31:0] rsp_q;
    logic rsp_v_q;
    logic f_valid;
    logic f_ready;
    logic [23:0] f_data;
    logic tick;

    ces_fifo #(.W(24), .D(DEPTH)) i_ces_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_word),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // Queue drains only between frames
    assign f_ready = st_q == ces_pkg::R_IDLE;
    assign tick = tmr_q == HALF - 16'h0001;

    always_ff @(posedge clk) begin
        if (srst || st_q == ces_pkg::R_IDLE || tick) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= ces_pkg::R_IDLE;
            clk_o_q <= 1'b0;
            drv_q <= 1'b0;
            brk_q <= 1'b0;
            ph_q <= '0;
            word_q <= '0;
            bit_q <= '0;
            n_q <= '0;
            k_q <= '0;
            rsp_q <= '0;
            rsp_v_q <= 1'b0;
        end else begin
            brk_q <= brk;
            rsp_v_q <= 1'b0;
            case (st_q)
                ces_pkg::R_IDLE: begin
                    if (f_valid) begin
                        word_q <= f_data;
                        // Reads need 32 data clocks plus one to release
                        n_q <= (f_data[7:0] == `CES_CMD_RD_SEC) ? `CES_RD_CLKS
                            : `CES_EW_CLKS;
                        ph_q <= '0;
                        st_q <= ces_pkg::R_START;
                    end
                end
                ces_pkg::R_START: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) begin
                            clk_o_q <= 1'b1;
                        end else if (ph_q == 2'h1) begin
                            drv_q <= 1'b1;
                        end else begin
                            clk_o_q <= 1'b0;
                            drv_q <= !word_q[0];
                            bit_q <= '0;
                            st_q <= ces_pkg::R_BITS;
                        end
                    end
                end
                ces_pkg::R_BITS: begin
                    if (tick && !clk_o_q) begin
                        clk_o_q <= 1'b1;
                    end else if (tick) begin
                        clk_o_q <= 1'b0;
                        bit_q <= bit_q + 5'h01;
                        word_q <= {1'b0, word_q[23:1]};
                        if (bit_q == `CES_FRAME_BITS - 5'h01) begin
                            drv_q <= 1'b1;
                            st_q <= ces_pkg::R_STOP;
                        end else begin
                            drv_q <= !word_q[1];
                        end
                    end
                end
                ces_pkg::R_STOP: begin
                    if (tick && !clk_o_q) begin
                        clk_o_q <= 1'b1;
                    end else if (tick) begin
                        drv_q <= 1'b0;
                        k_q <= '0;
                        rsp_q <= '0;
                        st_q <= ces_pkg::R_CLKS;
                    end
                end
                ces_pkg::R_CLKS: begin
                    if (tick && clk_o_q) begin
                        clk_o_q <= 1'b0;
                        k_q <= k_q + 9'h001;
                    end else if (tick) begin
                        clk_o_q <= 1'b1;
                        if (k_q <= `CES_SEC_BITS) begin
                            rsp_q <= {lnk.io, rsp_q[31:1]};
                        end
                        if (k_q == n_q) begin
                            st_q <= ces_pkg::R_DONE;
                        end
                    end
                end
                default: begin
                    clk_o_q <= 1'b0;
                    rsp_v_q <= 1'b1;
                    st_q <= ces_pkg::R_IDLE;
                end
            endcase
        end
    end

    assign lnk.lnk_clk = clk_o_q;
    assign lnk.lnk_rst = brk_q;
    assign lnk.io_rdr_o = 1'b0;
    assign lnk.io_rdr_oe = drv_q;
    assign rsp_valid = rsp_v_q;
    assign rsp_data = rsp_q;
    assign busy = st_q != ces_pkg::R_IDLE;
endmodule

// *** tb/ces_link_checker.sv ***
`timescale 1ns/1ns
module ces_link_checker (
    // System
    input wire logic clk,
    input wire logic srst,
    // Link
    input wire logic lnk_clk,
    input wire logic lnk_rst,
    input wire logic io_rdr_o,
    input wire logic io_rdr_oe,
    input wire logic io_dev_o,
    input wire logic io_dev_oe,
    input wire logic io,
    // Card status
    input wire logic verified,
    input wire logic [2:0] err_count
);
    logic clk_q;
    logic oe_q;
    logic proc_q;
    logic [8:0] cnt_q;
    wire link_fell = clk_q && !lnk_clk;
    // Processing starts at stop, while the link clock is high
    wire proc_start = io_dev_oe && !oe_q && lnk_clk && !lnk_rst;

    // Falls counted the way the card sees them, one edge late
    always_ff @(posedge clk) begin
        if (srst) begin
            clk_q <= 1'b0;
            oe_q <= 1'b0;
            proc_q <= 1'b0;
            cnt_q <= 9'h000;
        end else begin
            clk_q <= lnk_clk;
            oe_q <= io_dev_oe;
            proc_q <= proc_start || (proc_q && io_dev_oe);
            cnt_q <= proc_start ? 9'h000 : cnt_q + {8'h00, link_fell && proc_q};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    verified_at_reset_a: assert property ($past(srst) |-> !verified)
        else $error("verified set right after reset");
    verified_sticky_a: assert property (verified |=> verified)
        else $error("verified flag dropped");
    counter_no_erase_a: assert property (
        !verified |=> (err_count & ~$past(err_count)) == 3'h0)
        else $error("counter bit erased while unverified");
    counter_in_proc_a: assert property ($changed(err_count) |-> proc_q)
        else $error("counter changed outside processing");
    verify_on_compare_a: assert property ($rose(verified) |-> proc_q && cnt_q == 9'h002)
        else $error("verified set outside a compare");
    proc_length_a: assert property (
        $fell(io_dev_oe) && proc_q && !lnk_rst |-> cnt_q inside {9'h002, 9'h07c, 9'h0ff})
        else $error("processing released at a wrong count");
    proc_bound_a: assert property (proc_q |-> cnt_q <= 9'h0ff)
        else $error("processing longer than 255 clocks");
    release_clk_low_a: assert property ($fell(io_dev_oe) |-> !lnk_clk)
        else $error("line released while link clock high");
    no_contention_a: assert property (io_rdr_oe |-> !io_dev_oe)
        else $error("card drives during command entry");
    line_pulled_a: assert property (
        io_dev_oe || io_rdr_oe |-> !io && !io_dev_o && !io_rdr_o)
        else $error("driven line not low");
endmodule

// *** tb/card_eeprom_security_commands_bench.sv ***
`timescale 1ns/1ns
module card_eeprom_security_commands_bench;
    localparam int LIMIT = 90000;
    localparam logic [31:0] FAIL = 32'hfffffffe;
    logic clk;
    logic srst;
    logic cmd_valid;
    logic brk;
    logic [23:0] cmd_word;
    logic cmd_ready;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic verified;
    logic [2:0] err_count;
    logic rdr_busy;
    logic card_busy;
    int miscompares;
    int compares;
    int cycles;

    ces_link_if lnk_if();
    ces_reader #(.HALF(16'h0004), .DEPTH(4)) i_ces_reader (.clk(clk), .srst(srst),
        .lnk(lnk_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .brk(brk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(rdr_busy));
    ces_card #(.CODE_INIT(24'ha5a5a5)) i_ces_card (.clk(clk), .srst(srst), .lnk(lnk_if),
        .verified(verified), .err_count(err_count), .busy(card_busy));
    ces_link_checker chk_link (.clk(clk), .srst(srst), .lnk_clk(lnk_if.lnk_clk),
        .lnk_rst(lnk_if.lnk_rst), .io_rdr_o(lnk_if.io_rdr_o), .io_rdr_oe(lnk_if.io_rdr_oe),
        .io_dev_o(lnk_if.io_dev_o), .io_dev_oe(lnk_if.io_dev_oe), .io(lnk_if.io),
        .verified(verified), .err_count(err_count));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares = miscompares + 1;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded so a silent reader shows up as a mismatch, not a hang
    task automatic get_rsp(output logic [31:0] r);
        r = 32'hxxxxxxxx;
        for (int n = 0; n < 3000; n++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) begin
                r = rsp_data;
                break;
            end
        end
    endtask

    task automatic run(input logic [7:0] ctl, input logic [7:0] adr, input logic [7:0] dat,
        input logic [31:0] exp);
        logic [31:0] r;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word <= {dat, adr, ctl};
        @(posedge clk);
        cmd_valid <= 1'b0;
        get_rsp(r);
        chk(r, exp);
        chk({30'h0, rdr_busy, card_busy}, 32'h00000000);
    endtask

    task automatic s_read_locked();
        int n;
        logic [31:0] r;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word <= {8'h00, 8'h00, 8'h31};
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            if (cmd_ready !== 1'b1) break;
            n++;
            @(posedge clk);
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        chk(32'(n >= 4 && n <= 5), 32'h00000001);
        for (int k = 0; k < n; k++) begin
            get_rsp(r);
            chk(r, 32'h00000007);
        end
        run(8'h31, 8'hff, 8'h5a, 32'h00000007);
    endtask

    task automatic s_refusals();
        run(8'h30, 8'h00, 8'h00, 32'hffffffff);
        for (int a = 1; a < 4; a++) begin
            run(8'h33, 8'(a), 8'ha5, FAIL);
        end
        chk({31'h0, verified}, 32'h00000000);
        run(8'h38, 8'h05, 8'h5a, FAIL);
        run(8'h3c, 8'h05, 8'hff, FAIL);
        run(8'h39, 8'h01, 8'h00, FAIL);
        run(8'h39, 8'h00, 8'hff, FAIL);
        chk({29'h0, err_count}, 32'h00000007);
    endtask

    task automatic s_bad_order();
        run(8'h39, 8'h00, 8'h06, 32'h00000000);
        chk({29'h0, err_count}, 32'h00000006);
        run(8'h33, 8'h02, 8'ha5, FAIL);
        run(8'h33, 8'h01, 8'ha5, FAIL);
        run(8'h33, 8'h03, 8'ha5, FAIL);
        chk({31'h0, verified}, 32'h00000000);
        run(8'h39, 8'h00, 8'h02, 32'h00000000);
        run(8'h33, 8'h01, 8'ha5, FAIL);
        run(8'h33, 8'h02, 8'h5a, FAIL);
        run(8'h33, 8'h03, 8'ha5, FAIL);
        chk({31'h0, verified}, 32'h00000000);
    endtask

    task automatic s_verify();
        run(8'h39, 8'h00, 8'h04, 32'h00000000);
        for (int a = 1; a < 4; a++) begin
            run(8'h33, 8'(a), 8'ha5, FAIL);
        end
        chk({31'h0, verified}, 32'h00000001);
        run(8'h39, 8'h00, 8'hff, 32'h00000000);
        chk({29'h0, err_count}, 32'h00000007);
        run(8'h39, 8'h02, 8'h3c, 32'h00000000);
        run(8'h31, 8'h00, 8'h00, 32'ha53ca507);
    endtask

    task automatic s_protect();
        run(8'h38, 8'h05, 8'h5a, 32'h00000000);
        run(8'h3c, 8'h05, 8'h00, FAIL);
        run(8'h3c, 8'h05, 8'h5a, 32'h00000000);
        run(8'h3c, 8'h05, 8'h5a, FAIL);
        run(8'h38, 8'h05, 8'h00, FAIL);
    endtask

    initial begin
        srst = 1'b1;
        brk = 1'b0;
        cmd_valid = 1'b0;
        cmd_word = 24'h000000;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({31'h0, verified}, 32'h00000000);
        s_read_locked();
        s_refusals();
        s_bad_order();
        s_verify();
        s_protect();
        test_done();
    end
endmodule
